// ---- core/ast_map.svh ----
// Purpose: constants of the async serial transceiver
// Assumes: 100 MHz sys_clk_in
// Notes:   included by the ast_uart module only
`ifndef AST_MAP_SVH
`define AST_MAP_SVH

`define AST_DATA_W     8
`define AST_FIFO_DEPTH 16
// default 16x tick divider, about 115200 baud at 100 MHz
`define AST_BAUD_DIV   16'h0036
`define AST_PH_LAST    4'hF
`define AST_MID_TICK   4'h7
`define AST_LAST8      3'h7
`define AST_LAST7      3'h6
`define AST_LAST5      3'h4
`define AST_TXE_RST    1'b1
`define AST_TX_END_FLAG_RST   1'b1
`define AST_RXF_RST    1'b0
`define AST_ERR_RST    1'b0
`define AST_LINE_MARK  1'b1
`define AST_RDR_RST    8'h00

`endif

// ---- core/ast_pkg.sv ----
// Purpose: shared types of the async serial transceiver
// Assumes: nothing
// Notes:   numbers live in ast_map.svh
package ast_pkg;

  typedef enum logic [2:0] {
    TS_IDLE  = 3'b000,
    TS_START = 3'b001,
    TS_DATA  = 3'b010,
    TS_EXTRA = 3'b011,
    TS_STOP  = 3'b100
  } ast_tx_st_t;

  typedef enum logic [2:0] {
    RS_IDLE  = 3'b000,
    RS_START = 3'b001,
    RS_DATA  = 3'b010,
    RS_EXTRA = 3'b011,
    RS_STOP  = 3'b100
  } ast_rx_st_t;

endpackage : ast_pkg

// ---- core/ast_fifo.sv ----
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   read data comes straight from the array
`timescale 1ns/1ps
module ast_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic      [W-1:0] out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_out  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : ast_fifo

// ---- core/ast_uart.sv ----
// Purpose: full-duplex async serial transceiver, double-buffered both ways
// Assumes: control bits change only while tx_enable_in and rx_enable_in are low
// Notes:   async mode only; a 16-word FIFO feeds the transmit data register
`timescale 1ns/1ps
`include "ast_map.svh"
module ast_uart import ast_pkg::*; #(
  parameter logic [15:0] BAUD_DIV = `AST_BAUD_DIV
) (
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  input  wire logic       multiproc_bit_in,
  output logic      [7:0] rx_data_out,
  output logic            rx_mpb_out,
  input  wire logic       rx_read_in,
  input  wire logic       err_clear_in,
  input  wire logic       char_length_sel_in,
  input  wire logic       parity_enable_in,
  input  wire logic       multiproc_enable_in,
  input  wire logic       parity_mode_in,
  input  wire logic       stop_length_in,
  input  wire logic       clock_sel_hi_in,
  input  wire logic       clock_sel_lo_in,
  input  wire logic       tx_enable_in,
  input  wire logic       rx_enable_in,
  input  wire logic       rx_irq_enable_in,
  input  wire logic       tx_irq_enable_in,
  input  wire logic       tx_end_irq_enable_in,
  output logic            rx_full_flag_out,
  output logic            tx_empty_flag_out,
  output logic            tx_end_flag_out,
  output logic            parity_error_flag_out,
  output logic            framing_error_flag_out,
  output logic            overrun_error_flag_out,
  output logic            rx_full_request_out,
  output logic            tx_empty_request_out,
  output logic            tx_end_request_out,
  output logic            rx_error_request_out,
  input  wire logic       serial_rx_pin_in,
  output logic            serial_tx_pin_out,
  input  wire logic       serial_clock_pin_in,
  output logic            serial_clock_pin_out,
  output logic            serial_clock_pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // frame format decode

  logic [2:0] dlast;
  logic       has_extra;
  logic       extra_par;

  always_comb begin
    if (parity_enable_in && multiproc_enable_in) begin
      dlast     = `AST_LAST5;
      has_extra = char_length_sel_in;
      extra_par = 1'b1;
    end else begin
      dlast     = char_length_sel_in ? `AST_LAST7 : `AST_LAST8;
      has_extra = parity_enable_in | multiproc_enable_in;
      extra_par = parity_enable_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 16x tick: internal divider or external pin

  logic        k1_q, k2_q, k3_q;
  logic [15:0] baud_q;
  logic        sel_ext;
  logic        tick;

  assign sel_ext = clock_sel_hi_in & ~clock_sel_lo_in;
  // reserved select codes fall back to the internal divider
  assign tick = sel_ext ? (k2_q & ~k3_q) : (baud_q == BAUD_DIV - 16'h0001);

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      k1_q <= 1'b0;
      k2_q <= 1'b0;
      k3_q <= 1'b0;
    end else begin
      k1_q <= serial_clock_pin_in;
      k2_q <= k1_q;
      k3_q <= k2_q;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in || tick) begin
      baud_q <= 16'h0000;
    end else begin
      baud_q <= baud_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit data register fed by the FIFO

  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       pop;
  logic       tsr_load;
  logic       txe_q;
  logic       tx_end_flag_q;
  logic [7:0] tdr_q;

  assign pop = fifo_valid & txe_q & tx_enable_in;

  ast_fifo #(
    .W     (`AST_DATA_W),
    .DEPTH (`AST_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (tx_valid_in),
    .in_data_in    (tx_data_in),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (txe_q & tx_enable_in)
  );

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      tdr_q <= `AST_RDR_RST;
    end else if (pop) begin
      tdr_q <= fifo_data;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      txe_q <= `AST_TXE_RST;
    end else if (!tx_enable_in) begin
      txe_q <= 1'b1;
    end else if (tsr_load) begin
      txe_q <= 1'b1;
    end else if (pop) begin
      txe_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter

  ast_tx_st_t tx_st_q;
  logic [3:0] tph_q;
  logic [2:0] tcnt_q;
  logic       tstop_q;
  logic [7:0] tsr_q;
  logic       tpar_q;
  logic       txd_q;
  logic       sck_q;
  logic       bnd;
  logic       last_stop;
  logic       tx_end_flag_set;

  assign bnd       = tick & (tph_q == `AST_PH_LAST);
  assign last_stop = (tx_st_q == TS_STOP) & (tstop_q | ~stop_length_in);
  assign tsr_load  = bnd & tx_enable_in & ~txe_q & ((tx_st_q == TS_IDLE) | last_stop);
  assign tx_end_flag_set  = bnd & tx_enable_in & last_stop & txe_q;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      tph_q <= 4'h0;
    end else if (tick) begin
      tph_q <= tph_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in || !tx_enable_in) begin
      tx_st_q <= TS_IDLE;
      tcnt_q  <= 3'h0;
      tstop_q <= 1'b0;
      tsr_q   <= 8'h00;
      tpar_q  <= 1'b0;
    end else if (tsr_load) begin
      tx_st_q <= TS_START;
      tsr_q   <= tdr_q;
      // mask unused upper bits out of the parity
      // shift amount needs four bits, or the 8-bit mask wraps to zero
      tpar_q  <= ^(tdr_q & ~(8'hFF << ({1'b0, dlast} + 4'h1)));
    end else if (bnd) begin
      case (tx_st_q)
        TS_START: begin
          tx_st_q <= TS_DATA;
          tcnt_q  <= 3'h0;
        end
        TS_DATA: begin
          tsr_q <= {1'b0, tsr_q[7:1]};
          if (tcnt_q == dlast) begin
            tx_st_q <= has_extra ? TS_EXTRA : TS_STOP;
            tstop_q <= 1'b0;
          end else begin
            tcnt_q <= tcnt_q + 3'h1;
          end
        end
        TS_EXTRA: begin
          tx_st_q <= TS_STOP;
          tstop_q <= 1'b0;
        end
        TS_STOP: begin
          if (last_stop) begin
            tx_st_q <= TS_IDLE;
          end else begin
            tstop_q <= 1'b1;
          end
        end
        default: tx_st_q <= TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      txd_q <= `AST_LINE_MARK;
    end else begin
      case (tx_st_q)
        TS_START: txd_q <= 1'b0;
        TS_DATA:  txd_q <= tsr_q[0];
        TS_EXTRA: txd_q <= extra_par ? (tpar_q ^ parity_mode_in) : multiproc_bit_in;
        default:  txd_q <= `AST_LINE_MARK;
      endcase
    end
  end

  // bit clock rises as the tx bit phase passes its middle
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= tph_q[3];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      tx_end_flag_q <= `AST_TX_END_FLAG_RST;
    end else if (tx_end_flag_set) begin
      tx_end_flag_q <= 1'b1;
    end else if (pop) begin
      tx_end_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver

  ast_rx_st_t rx_st_q;
  logic       r1_q, r2_q, r3_q;
  logic [3:0] rcnt_q;
  logic [2:0] rbit_q;
  logic [7:0] rsr_q;
  logic       rpar_q;
  logic       rext_q;
  logic       strobe;
  logic       rx_done;
  logic       any_err;
  logic       par_bad;
  logic [7:0] rdata;
  logic       rxf_q, per_q, fer_q, oer_q, rmpb_q;
  logic [7:0] rdr_q;

  assign strobe  = tick & (rcnt_q == `AST_MID_TICK);
  assign rx_done = strobe & (rx_st_q == RS_STOP) & rx_enable_in;
  assign any_err = per_q | fer_q | oer_q;
  assign par_bad = has_extra & extra_par & ((rpar_q ^ rext_q) != parity_mode_in);

  always_comb begin
    case (dlast)
      `AST_LAST7: rdata = {1'b0, rsr_q[7:1]};
      `AST_LAST5: rdata = {3'b000, rsr_q[7:3]};
      default:    rdata = rsr_q;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      r1_q <= `AST_LINE_MARK;
      r2_q <= `AST_LINE_MARK;
      r3_q <= `AST_LINE_MARK;
    end else begin
      r1_q <= serial_rx_pin_in;
      r2_q <= r1_q;
      r3_q <= r2_q;
    end
  end

  // a set error flag blocks new frames until cleared
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in || !rx_enable_in) begin
      rx_st_q <= RS_IDLE;
      rcnt_q  <= 4'h0;
      rbit_q  <= 3'h0;
      rsr_q   <= 8'h00;
      rpar_q  <= 1'b0;
      rext_q  <= 1'b0;
    end else if (rx_st_q == RS_IDLE) begin
      if (r3_q && !r2_q && !any_err) begin
        rx_st_q <= RS_START;
        rcnt_q  <= 4'h0;
      end
    end else begin
      if (tick) begin
        rcnt_q <= rcnt_q + 4'h1;
      end
      if (strobe) begin
        case (rx_st_q)
          RS_START: begin
            rx_st_q <= r2_q ? RS_IDLE : RS_DATA;
            rbit_q  <= 3'h0;
            rpar_q  <= 1'b0;
          end
          RS_DATA: begin
            rsr_q  <= {r2_q, rsr_q[7:1]};
            rpar_q <= rpar_q ^ r2_q;
            if (rbit_q == dlast) begin
              rx_st_q <= has_extra ? RS_EXTRA : RS_STOP;
            end else begin
              rbit_q <= rbit_q + 3'h1;
            end
          end
          RS_EXTRA: begin
            rext_q  <= r2_q;
            rx_st_q <= RS_STOP;
          end
          // second stop bit is not checked; idle hunts the next edge
          RS_STOP: rx_st_q <= RS_IDLE;
          default: rx_st_q <= RS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rdr_q  <= `AST_RDR_RST;
      rmpb_q <= 1'b0;
    end else if (rx_done && !rxf_q) begin
      rdr_q  <= rdata;
      rmpb_q <= rext_q & has_extra & ~extra_par;
    end
  end

  // set wins over the host clear in every flag
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rxf_q <= `AST_RXF_RST;
    end else if (rx_done && !rxf_q && r2_q && !par_bad) begin
      rxf_q <= 1'b1;
    end else if (rx_read_in) begin
      rxf_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      per_q <= `AST_ERR_RST;
      fer_q <= `AST_ERR_RST;
      oer_q <= `AST_ERR_RST;
    end else begin
      per_q <= (rx_done & ~rxf_q & par_bad) | (per_q & ~err_clear_in);
      fer_q <= (rx_done & ~rxf_q & ~r2_q) | (fer_q & ~err_clear_in);
      oer_q <= (rx_done & rxf_q) | (oer_q & ~err_clear_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign serial_tx_pin_out       = txd_q;
  assign serial_clock_pin_out    = sck_q;
  assign serial_clock_pin_oe_out = ~clock_sel_hi_in & clock_sel_lo_in;
  assign rx_data_out             = rdr_q;
  assign rx_mpb_out              = rmpb_q;
  assign rx_full_flag_out        = rxf_q;
  assign tx_empty_flag_out       = txe_q;
  assign tx_end_flag_out         = tx_end_flag_q;
  assign parity_error_flag_out   = per_q;
  assign framing_error_flag_out  = fer_q;
  assign overrun_error_flag_out  = oer_q;
  assign rx_full_request_out     = rxf_q & rx_irq_enable_in;
  assign tx_empty_request_out    = txe_q & tx_irq_enable_in;
  assign tx_end_request_out      = tx_end_flag_q & tx_end_irq_enable_in;
  assign rx_error_request_out    = any_err & rx_irq_enable_in;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_rxf_set;
    $rose(rxf_q) |-> $past(rx_done) && !$past(par_bad);
  endproperty
  a_rxf_set: assert property (p_rxf_set) else $error("rx full without good frame");

  property p_load_txe;
    tsr_load |=> txe_q && tx_st_q == TS_START;
  endproperty
  a_load_txe: assert property (p_load_txe) else $error("load did not set tx empty");

  property p_tx_end_flag;
    $rose(tx_end_flag_q) |-> $past(txe_q) && $past(last_stop);
  endproperty
  a_tx_end_flag: assert property (p_tx_end_flag) else $error("tx end without empty");

  property p_start_low;
    tx_st_q == TS_START |=> !serial_tx_pin_out;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_idle_mark;
    tx_st_q == TS_IDLE ##1 tx_st_q == TS_IDLE |-> serial_tx_pin_out;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not mark");

  property p_txe_dis;
    !tx_enable_in |=> txe_q;
  endproperty
  a_txe_dis: assert property (p_txe_dis) else $error("tx empty not set");

  property p_rx_keep;
    !rx_enable_in && !rx_read_in && !err_clear_in
      |=> $stable(rdr_q) && $stable(rxf_q) && $stable(oer_q) && $stable(fer_q);
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx state lost on disable");

  property p_overrun;
    rx_done && rxf_q |=> oer_q && $stable(rdr_q);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  // counter restarts on the start edge so the 8th tick lands mid-bit
  property p_mid;
    rx_st_q == RS_IDLE ##1 rx_st_q == RS_START |-> rcnt_q == 4'h0 && !r3_q;
  endproperty
  a_mid: assert property (p_mid) else $error("sample off mid bit");

endmodule : ast_uart

// ---- dv/ast_remote_model.sv ----
// Purpose: remote serial device on the far end of the line
// Assumes: bit time is 16 ticks of DIV sys clocks
// Notes:   behavioural; tasks are called by the bench
`timescale 1ns/1ps
module ast_remote_model #(
  parameter int DIV = 4
) (
  input  wire logic sys_clk_in,
  input  wire logic line_in,
  output logic      line_out,
  output logic      ext_clk_out
);
  localparam int BIT = 16 * DIV;
  initial begin
    line_out = 1'b1;
    ext_clk_out = 1'b0;
  end
  // free-running 16x clock, never paused, also while the unit is set up
  always begin
    repeat (DIV / 2) @(negedge sys_clk_in);
    ext_clk_out = ~ext_clk_out;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [11:0] fr, input int len);
    for (int i = 0; i < len; i++) begin
      line_out = fr[i];
      repeat (BIT) @(negedge sys_clk_in);
    end
    line_out = 1'b1;
  endtask : send
  // samples at mid-bit so small phase offsets do not matter
  task automatic capture(input int len, output logic [11:0] fr);
    int t;
    fr = '1;
    t = 0;
    while (line_in !== 1'b0 && t < 40 * BIT) begin
      @(negedge sys_clk_in);
      t++;
    end
    repeat (BIT / 2) @(negedge sys_clk_in);
    for (int i = 0; i < len; i++) begin
      fr[i] = line_in;
      if (i < len - 1)
        repeat (BIT) @(negedge sys_clk_in);
    end
  endtask : capture
endmodule : ast_remote_model

// ---- dv/test_async_serial_transceiver.sv ----
// Purpose: self-checking bench of the async serial transceiver
// Assumes: small baud divider to keep the run short
// Notes:   rows cover formats and clock selects; hand tests follow
`timescale 1ns/1ps
module test_async_serial_transceiver;
  localparam int DIV = 4;
  localparam int BIT = 16 * DIV;
  // fmt = {char_length, parity_en, multiproc_en, parity_mode, stop_length, mpb}
  typedef struct {
    logic [1:0] sel;
    logic [5:0] fmt;
    logic [7:0] data;
    logic [7:0] exp_rx;
    int         len;
  } ast_row_t;
  ast_row_t rows [9] = '{
    '{2'h0, 6'h00, 8'hA5, 8'hA5, 10}, '{2'h1, 6'h02, 8'h5B, 8'h5B, 11},
    '{2'h2, 6'h09, 8'hA5, 8'hA5, 11}, '{2'h3, 6'h14, 8'h5B, 8'h5B, 11},
    '{2'h0, 6'h1A, 8'hA5, 8'h05, 8}, '{2'h1, 6'h20, 8'hA5, 8'h25, 9},
    '{2'h2, 6'h2B, 8'h5B, 8'h5B, 11}, '{2'h0, 6'h30, 8'hA5, 8'h25, 10},
    '{2'h0, 6'h3C, 8'h5B, 8'h1B, 8}};
  logic clk = 0, nrst = 0, tv = 0, rd = 0, ec = 0, multiproc_bit = 0, chr = 0, pe = 0, mp = 0;
  logic pm = 0, stl = 0, shi = 0, slo = 0, te = 0, re = 0, rx_irq_enable = 1, tx_irq_enable = 1, tx_end_irq_enable = 1;
  logic [7:0] td = 8'h00;
  logic [7:0] rxd;
  logic trdy, rmpb, rxf, txe, txend, parity_error_flag, framing_error_flag, overrun_error_flag, rq_rx, rq_te, rq_tx_end_flag, rq_err;
  logic txp, rxp, eclk, cko, ckoe;
  int   error_cnt = 0;
  int   n_checks = 0;
  int   cyc = 0;
  always #5 clk = ~clk;
  ast_uart #(.BAUD_DIV(16'(DIV))) u_ast_uart (
    .sys_clk_in(clk), .nrst_in(nrst), .tx_valid_in(tv), .tx_data_in(td), .tx_ready_out(trdy),
    .multiproc_bit_in(multiproc_bit), .rx_data_out(rxd), .rx_mpb_out(rmpb), .rx_read_in(rd),
    .err_clear_in(ec), .char_length_sel_in(chr), .parity_enable_in(pe),
    .multiproc_enable_in(mp), .parity_mode_in(pm), .stop_length_in(stl),
    .clock_sel_hi_in(shi), .clock_sel_lo_in(slo), .tx_enable_in(te), .rx_enable_in(re),
    .rx_irq_enable_in(rx_irq_enable), .tx_irq_enable_in(tx_irq_enable), .tx_end_irq_enable_in(tx_end_irq_enable),
    .rx_full_flag_out(rxf), .tx_empty_flag_out(txe), .tx_end_flag_out(txend),
    .parity_error_flag_out(parity_error_flag), .framing_error_flag_out(framing_error_flag), .overrun_error_flag_out(overrun_error_flag),
    .rx_full_request_out(rq_rx), .tx_empty_request_out(rq_te), .tx_end_request_out(rq_tx_end_flag),
    .rx_error_request_out(rq_err), .serial_rx_pin_in(rxp), .serial_tx_pin_out(txp),
    .serial_clock_pin_in(eclk), .serial_clock_pin_out(cko), .serial_clock_pin_oe_out(ckoe));
  ast_remote_model #(.DIV(DIV)) u_ast_remote_model (
    .sys_clk_in(clk), .line_in(txp), .line_out(rxp), .ext_clk_out(eclk));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic setfmt(input logic [1:0] sel, input logic [5:0] f);
    te = 1'b0;
    re = 1'b0;
    tick(1);
    {chr, pe, mp, pm, stl, multiproc_bit} = f;
    {shi, slo} = sel;
    tick(1);
  endtask : setfmt
  task automatic push(input logic [7:0] d);
    tv = 1'b1;
    td = d;
    tick(1);
    tv = 1'b0;
    tick(1);
  endtask : push
  task automatic rx_frame(input logic [11:0] fr);
    u_ast_remote_model.send(fr, 11);
    tick(4);
  endtask : rx_frame
  task automatic clear_flags();
    rd = 1'b1;
    ec = 1'b1;
    tick(1);
    rd = 1'b0;
    ec = 1'b0;
    tick(1);
  endtask : clear_flags
  // expected frame, lsb first, unused tail left high like the stop bits
  function automatic logic [11:0] build(input logic [5:0] f, input logic [7:0] d);
    logic [11:0] fr;
    int          n;
    n = (f[4] & f[3]) ? 5 : (f[5] ? 7 : 8);
    fr = '1;
    fr[0] = 1'b0;
    for (int k = 0; k < n; k++)
      fr[k + 1] = d[k];
    if (f[4] & (~f[3] | f[5]))
      fr[n + 1] = ^(d & 8'((16'h0001 << n) - 1)) ^ f[2];
    else if (f[3] & ~f[4])
      fr[n + 1] = f[0];
    return fr;
  endfunction : build
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      $display("MISMATCH run_length expected below %0d seen %0d", 60000, cyc);
      complete_run();
    end
  end
  // driven bit clock must rise half a bit before every line change
  logic cko_d = 1'b0;
  logic txp_d = 1'b1;
  int   since_rise = 0;
  always @(negedge clk) begin
    since_rise++;
    if (cko === 1'b1 && cko_d === 1'b0)
      since_rise = 0;
    if (nrst && ckoe === 1'b1 && txp !== txp_d)
      check("clk_mid", 12'(since_rise), 12'(BIT / 2));
    cko_d = cko;
    txp_d = txp;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] got;
    logic        acc;
    int          cnt;
    tick(12);
    nrst = 1'b1;
    tick(1);
    check("reset_state", {txp, txe, txend, rxf, parity_error_flag, framing_error_flag, overrun_error_flag, trdy}, 12'h0E1);
    check("reset_rdr", rxd, 12'h000);
    foreach (rows[i]) begin
      setfmt(rows[i].sel, rows[i].fmt);
      check("tx_empty_off", txe, 12'h001);
      check("clk_oe", ckoe, rows[i].sel == 2'h1);
      te = 1'b1;
      re = 1'b1;
      push(rows[i].data);
      fork
        u_ast_remote_model.capture(rows[i].len, got);
        u_ast_remote_model.send(build(rows[i].fmt, rows[i].data), rows[i].len);
        begin
          tick(3 * BIT);
          check("mid_tx", {txend, txe}, 12'h001);
        end
      join
      tick(BIT);
      check("tx_frame", got, build(rows[i].fmt, rows[i].data));
      check("rx_data", rxd, rows[i].exp_rx);
      check("rx_mpb", rmpb, rows[i].fmt[3] & ~rows[i].fmt[4] & rows[i].fmt[0]);
      check("rx_flags", {rxf, parity_error_flag, framing_error_flag, overrun_error_flag}, 12'h008);
      check("requests", {rq_rx, rq_te, rq_tx_end_flag, rq_err}, 12'h00E);
      check("tx_idle", {txp, txend}, 12'h003);
      clear_flags();
    end
    setfmt(2'h0, 6'h10);
    te = 1'b1;
    re = 1'b1;
    rx_frame(build(6'h10, 8'h3C));
    rx_frame(build(6'h10, 8'hC3));
    check("overrun", {rxf, overrun_error_flag, rq_err}, 12'h007);
    check("overrun_rdr", rxd, 12'h03C);
    re = 1'b0;
    tick(2);
    check("rx_off_keep", {rxf, overrun_error_flag, rxd}, 12'h33C);
    re = 1'b1;
    clear_flags();
    check("cleared", {rxf, parity_error_flag, framing_error_flag, overrun_error_flag}, 12'h000);
    rx_frame(build(6'h10, 8'h5A) & 12'hBFF);
    check("framing", {rxf, framing_error_flag, rxd}, 12'h15A);
    clear_flags();
    rx_frame(build(6'h10, 8'hA6) ^ 12'h200);
    check("parity", {rxf, parity_error_flag, rxd}, 12'h1A6);
    rx_irq_enable = 1'b0;
    tx_irq_enable = 1'b0;
    tx_end_irq_enable = 1'b0;
    tick(1);
    check("masked", {rq_rx, rq_te, rq_tx_end_flag, rq_err}, 12'h000);
    rx_irq_enable = 1'b1;
    tx_irq_enable = 1'b1;
    tx_end_irq_enable = 1'b1;
    clear_flags();
    setfmt(2'h0, 6'h00);
    te = 1'b1;
    push(8'h11);
    push(8'h22);
    tick(2 * BIT);
    te = 1'b0;
    tick(1);
    check("te_off_empty", txe, 12'h001);
    tick(12 * BIT);
    check("te_off_mark", txp, 12'h001);
    // fill with the transmitter off so nothing drains meanwhile
    tv = 1'b1;
    cnt = 0;
    for (int k = 0; k < 20; k++) begin
      td = 8'h40 + 8'(cnt);
      acc = trdy;
      tick(1);
      if (acc === 1'b1)
        cnt++;
    end
    tv = 1'b0;
    check("fifo_fill", 12'(cnt), 12'h010);
    check("fifo_full", trdy, 12'h000);
    te = 1'b1;
    for (int j = 0; j < 16; j++) begin
      u_ast_remote_model.capture(10, got);
      check("drain", got, build(6'h00, 8'h40 + 8'(j)));
    end
    tick(2 * BIT);
    check("drained", {trdy, txe, txend, txp}, 12'h00F);
    complete_run();
  end
endmodule : test_async_serial_transceiver
